// [rtl/eal_pkg.sv]
// constants, opcodes and flag layout of the eight-bit arithmetic and logic unit
// ==========================================================================
package eal_pkg;

    // ======================================================================
    // status flag bit positions
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_V = 3;
    localparam int unsigned FLAG_S = 4;
    localparam int unsigned FLAG_H = 5;

    // ======================================================================
    // reset values and fixed constants
    localparam logic [7:0]  FLAGS_RST  = 8'h00;
    localparam logic [7:0]  RESULT_RST = 8'h00;
    localparam logic [15:0] WORD_RST   = 16'h0000;
    localparam logic [7:0]  ALL_ONES   = 8'hff;

    // ======================================================================
    // cycle counts per operation class
    localparam int unsigned BYTE_CLOCKS = 1;
    localparam int unsigned WORD_CLOCKS = 2;

    // ======================================================================
    // operation codes
    typedef enum logic [4:0] {
        OP_SUM                  = 5'h00,
        OP_SUM_CARRY            = 5'h01,
        OP_WORD_IMMEDIATE_SUM   = 5'h02,
        OP_DIFFERENCE           = 5'h03,
        OP_CONSTANT_DIFFERENCE  = 5'h04,
        OP_DIFFERENCE_WITH_BORROW          = 5'h05,
        OP_CONSTANT_DIFFERENCE_WITH_BORROW = 5'h06,
        OP_WORD_IMMEDIATE_DIFFERENCE       = 5'h07,
        OP_CONJUNCTION          = 5'h08,
        OP_CONSTANT_MASK_CONJUNCTION       = 5'h09,
        OP_MERGE                = 5'h0a,
        OP_CONSTANT_MERGE       = 5'h0b,
        OP_EXCLUSIVE_MERGE      = 5'h0c,
        OP_ONES_COMPLEMENT      = 5'h0d,
        OP_TWOS_COMPLEMENT      = 5'h0e,
        OP_BIT_SET_MASK         = 5'h0f,
        OP_BIT_CLEAR_MASK       = 5'h10
    } eal_op_e;

    typedef enum logic [0:0] {
        ST_IDLE    = 1'b0,
        ST_WORD_HI = 1'b1
    } eal_state_e;

endpackage

// [rtl/eal_alu.sv]
// arithmetic and logic datapath with status flags
`timescale 1ns/10ps
module eal_alu (
    input  wire logic          ref_clk_in,  // 10 MHz core clock
    input  wire logic          srst_in,     // synchronous reset, high
    input  wire logic          start_in,    // operation valid
    input  eal_pkg::eal_op_e   op_in,       // operation code
    input  wire logic [7:0]    rd_in,       // destination register value
    input  wire logic [7:0]    rr_in,       // source register value
    input  wire logic [7:0]    imm_in,      // immediate constant or mask
    input  wire logic [15:0]   word_in,     // register pair, high:low
    output logic               busy_out,    // word op in second clock
    output logic               done_out,    // one-cycle completion pulse
    output logic [7:0]         result_out,  // byte result
    output logic [15:0]        word_out,    // word result
    output logic [7:0]         flags_out    // status flags
);
    import eal_pkg::*;

    // ======================================================================
    // state
    eal_state_e  state_r, state_nxt;
    logic [7:0]  flags_r, flags_nxt;
    logic [7:0]  result_r, result_nxt;
    logic [15:0] word_r, word_nxt;
    logic        done_r, done_nxt;
    logic [7:0]  lo_r, lo_nxt;
    logic [7:0]  hi_op_r, hi_op_nxt;
    logic        cy_r, cy_nxt;
    logic        wsub_r, wsub_nxt;

    // ======================================================================
    // operand and operation decode
    logic       take;
    logic       use_imm;
    logic       use_cin;
    logic       is_sub;
    logic       is_add;
    logic       is_logic;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] r;
    logic [8:0] ext9;
    logic [8:0] hi9;
    logic [7:0] hr;

    assign take     = start_in && (state_r == ST_IDLE);
    assign busy_out = (state_r == ST_WORD_HI);

    always_comb begin
        use_imm = (op_in == OP_CONSTANT_DIFFERENCE) ||
                  (op_in == OP_CONSTANT_DIFFERENCE_WITH_BORROW) ||
                  (op_in == OP_CONSTANT_MASK_CONJUNCTION) ||
                  (op_in == OP_CONSTANT_MERGE) ||
                  (op_in == OP_BIT_SET_MASK) || (op_in == OP_BIT_CLEAR_MASK);
        use_cin = (op_in == OP_SUM_CARRY) || (op_in == OP_DIFFERENCE_WITH_BORROW) ||
                  (op_in == OP_CONSTANT_DIFFERENCE_WITH_BORROW);
        is_add  = (op_in == OP_SUM) || (op_in == OP_SUM_CARRY);
        is_sub  = (op_in == OP_DIFFERENCE) || (op_in == OP_CONSTANT_DIFFERENCE) ||
                  (op_in == OP_DIFFERENCE_WITH_BORROW) ||
                  (op_in == OP_CONSTANT_DIFFERENCE_WITH_BORROW) ||
                  (op_in == OP_TWOS_COMPLEMENT);
        is_logic = (op_in == OP_CONJUNCTION) || (op_in == OP_CONSTANT_MASK_CONJUNCTION) ||
                   (op_in == OP_MERGE) || (op_in == OP_CONSTANT_MERGE) ||
                   (op_in == OP_EXCLUSIVE_MERGE) || (op_in == OP_BIT_SET_MASK) ||
                   (op_in == OP_BIT_CLEAR_MASK);
        // twos complement is zero minus the register
        a = (op_in == OP_TWOS_COMPLEMENT) ? 8'h00 : rd_in;
        b = (op_in == OP_TWOS_COMPLEMENT) ? rd_in : (use_imm ? imm_in : rr_in);
    end

    // ======================================================================
    // next-state and datapath
    always_comb begin
        state_nxt  = state_r;
        flags_nxt  = flags_r;
        result_nxt = result_r;
        word_nxt   = word_r;
        done_nxt   = 1'b0;
        lo_nxt     = lo_r;
        hi_op_nxt  = hi_op_r;
        cy_nxt     = cy_r;
        wsub_nxt   = wsub_r;
        r          = 8'h00;
        ext9       = 9'h000;
        hi9        = 9'h000;
        hr         = 8'h00;
        case (state_r)
            ST_IDLE: begin
                if (take) begin
                    if (is_add) begin
                        ext9 = {1'b0, a} + {1'b0, b} + {8'h00, use_cin & flags_r[FLAG_C]};
                        r = ext9[7:0];
                        flags_nxt[FLAG_C] = ext9[8];
                        flags_nxt[FLAG_H] = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
                        flags_nxt[FLAG_V] = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
                        flags_nxt[FLAG_N] = r[7];
                        flags_nxt[FLAG_Z] = (r == 8'h00);
                        result_nxt = r;
                        done_nxt   = 1'b1;
                    end else if (is_sub) begin
                        ext9 = {1'b0, a} - {1'b0, b} - {8'h00, use_cin & flags_r[FLAG_C]};
                        r = ext9[7:0];
                        flags_nxt[FLAG_C] = ext9[8];
                        flags_nxt[FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
                        flags_nxt[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
                        flags_nxt[FLAG_N] = r[7];
                        flags_nxt[FLAG_Z] = (r == 8'h00);
                        result_nxt = r;
                        done_nxt   = 1'b1;
                    end else if (is_logic) begin
                        case (op_in)
                            OP_CONJUNCTION, OP_CONSTANT_MASK_CONJUNCTION: r = a & b;
                            OP_MERGE, OP_CONSTANT_MERGE:                  r = a | b;
                            OP_EXCLUSIVE_MERGE:                           r = a ^ b;
                            OP_BIT_SET_MASK:                              r = a | b;
                            OP_BIT_CLEAR_MASK:                r = a & (ALL_ONES - b);
                            default:                                      r = a;
                        endcase
                        flags_nxt[FLAG_V] = 1'b0;
                        flags_nxt[FLAG_N] = r[7];
                        flags_nxt[FLAG_Z] = (r == 8'h00);
                        result_nxt = r;
                        done_nxt   = 1'b1;
                    end else if (op_in == OP_ONES_COMPLEMENT) begin
                        r = ALL_ONES - rd_in;
                        flags_nxt[FLAG_C] = 1'b1;
                        flags_nxt[FLAG_V] = 1'b0;
                        flags_nxt[FLAG_N] = r[7];
                        flags_nxt[FLAG_Z] = (r == 8'h00);
                        result_nxt = r;
                        done_nxt   = 1'b1;
                    end else if ((op_in == OP_WORD_IMMEDIATE_SUM) ||
                                 (op_in == OP_WORD_IMMEDIATE_DIFFERENCE)) begin
                        // low byte now, high byte next clock
                        wsub_nxt = (op_in == OP_WORD_IMMEDIATE_DIFFERENCE);
                        if (op_in == OP_WORD_IMMEDIATE_DIFFERENCE) begin
                            ext9 = {1'b0, word_in[7:0]} - {1'b0, imm_in};
                        end else begin
                            ext9 = {1'b0, word_in[7:0]} + {1'b0, imm_in};
                        end
                        lo_nxt    = ext9[7:0];
                        cy_nxt    = ext9[8];
                        hi_op_nxt = word_in[15:8];
                        state_nxt = ST_WORD_HI;
                    end
                end
            end
            ST_WORD_HI: begin
                if (wsub_r) begin
                    hi9 = {1'b0, hi_op_r} - {8'h00, cy_r};
                end else begin
                    hi9 = {1'b0, hi_op_r} + {8'h00, cy_r};
                end
                hr = hi9[7:0];
                if (wsub_r) begin
                    flags_nxt[FLAG_V] = hi_op_r[7] & ~hr[7];
                    flags_nxt[FLAG_C] = hr[7] & ~hi_op_r[7];
                    flags_nxt[FLAG_S] = hr[7] ^ (hi_op_r[7] & ~hr[7]);
                end else begin
                    flags_nxt[FLAG_V] = ~hi_op_r[7] & hr[7];
                    flags_nxt[FLAG_C] = ~hr[7] & hi_op_r[7];
                    flags_nxt[FLAG_S] = hr[7] ^ (~hi_op_r[7] & hr[7]);
                end
                flags_nxt[FLAG_N] = hr[7];
                flags_nxt[FLAG_Z] = ({hr, lo_r} == 16'h0000);
                word_nxt  = {hr, lo_r};
                done_nxt  = 1'b1;
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            state_r  <= ST_IDLE;
            flags_r  <= FLAGS_RST;
            result_r <= RESULT_RST;
            word_r   <= WORD_RST;
            done_r   <= 1'b0;
            lo_r     <= RESULT_RST;
            hi_op_r  <= RESULT_RST;
            cy_r     <= 1'b0;
            wsub_r   <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            flags_r  <= flags_nxt;
            result_r <= result_nxt;
            word_r   <= word_nxt;
            done_r   <= done_nxt;
            lo_r     <= lo_nxt;
            hi_op_r  <= hi_op_nxt;
            cy_r     <= cy_nxt;
            wsub_r   <= wsub_nxt;
        end
    end

    assign done_out   = done_r;
    assign result_out = result_r;
    assign word_out   = word_r;
    assign flags_out  = flags_r;

    // ======================================================================
    // checks
    a_add_result: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (take && op_in == OP_SUM) |=> done_out &&
        result_out == 8'($past(rd_in) + $past(rr_in)))
        else $error("add result wrong");

    a_word_sum: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (take && op_in == OP_WORD_IMMEDIATE_SUM) |=> !done_out ##1
        (done_out && word_out == 16'($past(word_in, 2) + {8'h00, $past(imm_in, 2)})))
        else $error("word add wrong");

    a_const_diff: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (take && op_in == OP_CONSTANT_DIFFERENCE) |=> done_out &&
        result_out == 8'($past(rd_in) - $past(imm_in)))
        else $error("constant subtract wrong");

    a_borrow_diff: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (take && op_in == OP_DIFFERENCE_WITH_BORROW) |=> result_out ==
        8'($past(rd_in) - $past(rr_in) - {7'h00, $past(flags_out[FLAG_C])}))
        else $error("subtract with carry wrong");

    a_const_borrow: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (take && op_in == OP_CONSTANT_DIFFERENCE_WITH_BORROW) |=> flags_out[FLAG_Z] ==
        (8'($past(rd_in) - $past(imm_in) - {7'h00, $past(flags_out[FLAG_C])}) == 8'h00))
        else $error("constant subtract with carry zero flag wrong");

    a_word_diff: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (take && op_in == OP_WORD_IMMEDIATE_DIFFERENCE) |=> busy_out ##1
        (done_out && word_out == 16'($past(word_in, 2) - {8'h00, $past(imm_in, 2)})))
        else $error("word subtract wrong");

    a_and_flags: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (take && op_in == OP_CONJUNCTION) |=> !flags_out[FLAG_V] &&
        result_out == ($past(rd_in) & $past(rr_in)) && $stable(flags_out[FLAG_C]))
        else $error("and result or flags wrong");

    a_xor_result: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (take && op_in == OP_EXCLUSIVE_MERGE) |=>
        result_out == ($past(rd_in) ^ $past(rr_in)) && flags_out[FLAG_N] == result_out[7])
        else $error("exclusive or wrong");

    a_set_bits: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (take && op_in == OP_BIT_SET_MASK) |=> (result_out & $past(imm_in)) == $past(imm_in))
        else $error("set bits not forced");

    a_clear_bits: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (take && op_in == OP_BIT_CLEAR_MASK) |=> (result_out & $past(imm_in)) == 8'h00)
        else $error("clear bits not forced");

    a_logic_keeps: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (take && is_logic) |=> $stable(flags_out[FLAG_H]) && $stable(flags_out[FLAG_S]))
        else $error("unlisted flag changed");

    a_twos_comp: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (take && op_in == OP_TWOS_COMPLEMENT) |=> done_out &&
        result_out == 8'(8'h00 - $past(rd_in)) && flags_out[FLAG_C] == ($past(rd_in) != 8'h00))
        else $error("twos complement wrong");

endmodule

// [dv/testbench.sv]
// self-checking testbench for the eight-bit arithmetic and logic unit
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
    import eal_pkg::*;

    // ======================================================================
    // stimulus and observation
    logic          ref_clk_in;
    logic          srst_in;
    logic          start_in;
    eal_op_e       op_in;
    logic [7:0]    rd_in;
    logic [7:0]    rr_in;
    logic [7:0]    imm_in;
    logic [15:0]   word_in;
    logic          busy_out;
    logic          done_out;
    logic [7:0]    result_out;
    logic [15:0]   word_out;
    logic [7:0]    flags_out;
    int            bad_count = 0;
    int            n_tests = 0;
    logic [7:0]    exp_r = RESULT_RST;
    logic [15:0]   exp_w = WORD_RST;
    logic [7:0]    exp_f = FLAGS_RST;

    eal_alu DUT (
        .ref_clk_in (ref_clk_in),
        .srst_in    (srst_in),
        .start_in   (start_in),
        .op_in      (op_in),
        .rd_in      (rd_in),
        .rr_in      (rr_in),
        .imm_in     (imm_in),
        .word_in    (word_in),
        .busy_out   (busy_out),
        .done_out   (done_out),
        .result_out (result_out),
        .word_out   (word_out),
        .flags_out  (flags_out)
    );

    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end

    // ======================================================================
    // reference model
    function automatic logic [15:0] calc(eal_op_e op, logic [7:0] a, logic [7:0] rr,
                                         logic [7:0] k, logic [7:0] f);
        logic [7:0] b, r, nf, ca, cb, cr;
        logic       cin, sub, arith;
        nf = f;
        b = (op inside {OP_CONSTANT_DIFFERENCE, OP_CONSTANT_DIFFERENCE_WITH_BORROW,
            OP_CONSTANT_MASK_CONJUNCTION, OP_CONSTANT_MERGE, OP_BIT_SET_MASK,
            OP_BIT_CLEAR_MASK}) ? k : rr;
        sub = op inside {OP_DIFFERENCE, OP_CONSTANT_DIFFERENCE, OP_DIFFERENCE_WITH_BORROW,
            OP_CONSTANT_DIFFERENCE_WITH_BORROW, OP_TWOS_COMPLEMENT};
        arith = sub | (op inside {OP_SUM, OP_SUM_CARRY});
        cin = (op inside {OP_SUM_CARRY, OP_DIFFERENCE_WITH_BORROW,
            OP_CONSTANT_DIFFERENCE_WITH_BORROW}) & f[FLAG_C];
        if (op == OP_TWOS_COMPLEMENT) begin
            b = a;
            a = 8'h00;
        end
        case (op)
            OP_CONJUNCTION, OP_CONSTANT_MASK_CONJUNCTION: r = a & b;
            OP_MERGE, OP_CONSTANT_MERGE, OP_BIT_SET_MASK: r = a | b;
            OP_EXCLUSIVE_MERGE: r = a ^ b;
            OP_BIT_CLEAR_MASK: r = a & (8'hff - b);
            OP_ONES_COMPLEMENT: r = 8'hff - a;
            default: r = sub ? a - b - {7'h00, cin} : a + b + {7'h00, cin};
        endcase
        nf[FLAG_Z] = (r == 8'h00);
        nf[FLAG_N] = r[7];
        nf[FLAG_V] = 1'b0;
        if (op == OP_ONES_COMPLEMENT) begin
            nf[FLAG_C] = 1'b1;
        end
        if (arith) begin
            ca = sub ? ~a : a;
            cb = sub ? ~b : b;
            cr = sub ? ~r : r;
            nf[FLAG_C] = ca[7] & b[7] | b[7] & ~cr[7] | ~cr[7] & ca[7];
            nf[FLAG_H] = ca[3] & b[3] | b[3] & ~cr[3] | ~cr[3] & ca[3];
            nf[FLAG_V] = a[7] & cb[7] & ~r[7] | ~a[7] & ~cb[7] & r[7];
        end
        return {r, nf};
    endfunction

    function automatic logic [23:0] wcalc(logic sub, logic [15:0] w, logic [7:0] k,
                                          logic [7:0] f);
        logic [15:0] r;
        logic [7:0]  nf;
        nf = f;
        r = sub ? w - {8'h00, k} : w + {8'h00, k};
        nf[FLAG_Z] = (r == 16'h0000);
        nf[FLAG_N] = r[15];
        nf[FLAG_V] = sub ? (w[15] & ~r[15]) : (~w[15] & r[15]);
        nf[FLAG_C] = sub ? (r[15] & ~w[15]) : (~r[15] & w[15]);
        nf[FLAG_S] = nf[FLAG_N] ^ nf[FLAG_V];
        return {r, nf};
    endfunction

    // ======================================================================
    // drivers, called just after a rising edge
    task automatic drive(eal_op_e op, logic [7:0] a, logic [7:0] rr, logic [7:0] k,
                         logic [15:0] w);
        start_in <= 1'b1;
        op_in <= op;
        rd_in <= a;
        rr_in <= rr;
        imm_in <= k;
        word_in <= w;
    endtask

    task automatic byte_op(eal_op_e op, logic [7:0] a, logic [7:0] rr, logic [7:0] k);
        {exp_r, exp_f} = calc(op, a, rr, k, exp_f);
        drive(op, a, rr, k, 16'h5a5a);
        @(posedge ref_clk_in);
        start_in <= 1'b0;
        @(negedge ref_clk_in);
        `CHK(done_out, 1'b1)
        `CHK(result_out, exp_r)
        `CHK(flags_out, exp_f)
        `CHK(word_out, exp_w)
        @(posedge ref_clk_in);
    endtask

    task automatic word_op(logic sub, logic [15:0] w, logic [7:0] k);
        {exp_w, exp_f} = wcalc(sub, w, k, exp_f);
        drive(sub ? OP_WORD_IMMEDIATE_DIFFERENCE : OP_WORD_IMMEDIATE_SUM, 8'h33, 8'h44, k, w);
        @(posedge ref_clk_in);
        start_in <= 1'b0;
        @(negedge ref_clk_in);
        `CHK({busy_out, done_out}, 2'b10)
        @(negedge ref_clk_in);
        `CHK({busy_out, done_out}, 2'b01)
        `CHK(word_out, exp_w)
        `CHK(flags_out, exp_f)
        `CHK(result_out, exp_r)
        @(posedge ref_clk_in);
    endtask

    // ======================================================================
    // scenarios
    task automatic test_reset();
        @(negedge ref_clk_in);
        `CHK({busy_out, done_out, result_out, word_out, flags_out}, 34'h0)
        @(posedge ref_clk_in);
        $display("test reset done");
    endtask

    task automatic test_mid_reset();
        srst_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        exp_r = RESULT_RST;
        exp_w = WORD_RST;
        exp_f = FLAGS_RST;
        @(negedge ref_clk_in);
        `CHK({busy_out, done_out, result_out, word_out, flags_out}, 34'h0)
        @(posedge ref_clk_in);
        // carry must be clear again, so no carry is added here
        byte_op(OP_SUM_CARRY, 8'h01, 8'h01, 8'h00);
        $display("test mid reset done");
    endtask

    task automatic test_byte_ops();
        byte_op(OP_SUM, 8'h0f, 8'h01, 8'h55);
        byte_op(OP_SUM, 8'hff, 8'h01, 8'h55);
        byte_op(OP_SUM_CARRY, 8'h7f, 8'h00, 8'h55);
        byte_op(OP_DIFFERENCE, 8'h10, 8'h01, 8'h55);
        byte_op(OP_CONSTANT_DIFFERENCE, 8'h80, 8'h55, 8'h01);
        byte_op(OP_CONSTANT_DIFFERENCE, 8'h01, 8'h55, 8'h02);
        byte_op(OP_DIFFERENCE_WITH_BORROW, 8'h01, 8'h00, 8'h55);
        byte_op(OP_TWOS_COMPLEMENT, 8'h00, 8'h55, 8'h55);
        byte_op(OP_CONSTANT_DIFFERENCE_WITH_BORROW, 8'h10, 8'h55, 8'h0f);
        byte_op(OP_CONJUNCTION, 8'hf3, 8'h8c, 8'h00);
        byte_op(OP_CONSTANT_MASK_CONJUNCTION, 8'h0f, 8'hff, 8'hf0);
        byte_op(OP_MERGE, 8'h81, 8'h02, 8'h00);
        byte_op(OP_CONSTANT_MERGE, 8'h00, 8'hff, 8'h00);
        byte_op(OP_EXCLUSIVE_MERGE, 8'h5a, 8'hda, 8'h0f);
        byte_op(OP_BIT_SET_MASK, 8'h01, 8'h00, 8'h90);
        byte_op(OP_BIT_CLEAR_MASK, 8'hff, 8'h00, 8'h0f);
        byte_op(OP_ONES_COMPLEMENT, 8'h5a, 8'h00, 8'h00);
        byte_op(OP_TWOS_COMPLEMENT, 8'h80, 8'h00, 8'h00);
        $display("test byte ops done");
    endtask

    task automatic test_word_ops();
        word_op(1'b0, 16'hffc0, 8'h40);
        word_op(1'b0, 16'h7fff, 8'h01);
        word_op(1'b1, 16'h8000, 8'h01);
        word_op(1'b1, 16'h0000, 8'hff);
        byte_op(OP_SUM_CARRY, 8'h10, 8'h20, 8'h00);
        $display("test word ops done");
    endtask

    task automatic test_back_to_back();
        logic [7:0] r1, f1;
        {r1, f1} = calc(OP_CONSTANT_MERGE, 8'h0f, 8'h00, 8'hf0, exp_f);
        {exp_r, exp_f} = calc(OP_EXCLUSIVE_MERGE, 8'h3c, 8'h3c, 8'h00, f1);
        drive(OP_CONSTANT_MERGE, 8'h0f, 8'h00, 8'hf0, 16'h0000);
        @(posedge ref_clk_in);
        drive(OP_EXCLUSIVE_MERGE, 8'h3c, 8'h3c, 8'h00, 16'h0000);
        @(negedge ref_clk_in);
        `CHK({done_out, result_out, flags_out}, {1'b1, r1, f1})
        @(posedge ref_clk_in);
        start_in <= 1'b0;
        @(negedge ref_clk_in);
        `CHK({done_out, result_out, flags_out}, {1'b1, exp_r, exp_f})
        @(posedge ref_clk_in);
        $display("test back to back done");
    endtask

    task automatic test_refused();
        logic [7:0] f1;
        {exp_w, f1} = wcalc(1'b0, 16'h00ff, 8'h01, exp_f);
        drive(OP_WORD_IMMEDIATE_SUM, 8'h00, 8'h00, 8'h01, 16'h00ff);
        @(posedge ref_clk_in);
        drive(OP_TWOS_COMPLEMENT, 8'h01, 8'h00, 8'h00, 16'h0000);
        @(negedge ref_clk_in);
        `CHK({busy_out, done_out}, 2'b10)
        @(posedge ref_clk_in);
        drive(OP_SUM, 8'h01, 8'h02, 8'h00, 16'h0000);
        @(negedge ref_clk_in);
        `CHK({done_out, word_out, flags_out, result_out}, {1'b1, exp_w, f1, exp_r})
        {exp_r, exp_f} = calc(OP_SUM, 8'h01, 8'h02, 8'h00, f1);
        @(posedge ref_clk_in);
        start_in <= 1'b0;
        @(negedge ref_clk_in);
        `CHK({done_out, result_out, flags_out}, {1'b1, exp_r, exp_f})
        @(negedge ref_clk_in);
        `CHK(done_out, 1'b0)
        @(posedge ref_clk_in);
        $display("test refused during busy done");
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ======================================================================
    // main sequence
    initial begin
        srst_in = 1'b1;
        start_in = 1'b0;
        op_in = OP_SUM;
        rd_in = 8'h00;
        rr_in = 8'h00;
        imm_in = 8'h00;
        word_in = 16'h0000;
        repeat (8) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        test_reset();
        test_byte_ops();
        test_word_ops();
        test_back_to_back();
        test_refused();
        test_mid_reset();
        give_verdict();
    end
endmodule
